/* File: rtl/adc_retrig_dma_sync.sv */
// receive dma pacing controller with apb registers and four host irq lines
// assumes fifo flags and data are synchronous to pclk; host reads fifo data over apb
//
// Summary of operation
// - active only in single-run or continuous mode
// - entering acquisition mode starts hunting for start
// - start event is full or almost-full
// - two-channel takes events from fifo one
// - stop event is empty or almost-empty
// - transfer ends on stop or sequence error
// - repeat sync events during the transfer
// - sync active while awaiting host reads
// - retrigger sync after required reads complete
// - retrigger until stop event seen
// - decode host reads of fifo data
// - sync routable to any of four lines
// - positive polarity drives line low
// - flag error on bad two-channel sequence
// - format ten selects two-channel operation
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
module adc_retrig_dma_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic one_full,
    input wire logic one_almost_full,
    input wire logic one_empty,
    input wire logic one_almost_empty,
    input wire logic two_full,
    input wire logic two_almost_full,
    input wire logic two_empty,
    input wire logic two_almost_empty,
    input wire logic [31:0] rx_fifo_one_rdata,
    input wire logic [31:0] rx_fifo_two_rdata,
    output logic rx_fifo_one_pop,
    output logic rx_fifo_two_pop,
    output logic [3:0] host_irq_n
);
    logic [3:0] ctrl_one_q;
    logic [1:0] ctrl_three_q;
    logic [1:0] irq_sel_q [adc_sync_pkg::NUM_IRQ_LINES];
    logic seq_err_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic pop_one_q;
    logic pop_two_q;
    logic [3:0] irq_n_q;
    adc_sync_pkg::sync_state_t st_q;
    adc_sync_pkg::sync_state_t st_d;

    logic [1:0] mode;
    logic [1:0] fmt;
    logic acq_on;
    logic take;
    logic wr_take;
    logic rd_take;
    logic map_hit;
    logic rd_one_hit;
    logic rd_two_hit;
    logic start_evt;
    logic stop_evt;
    logic reads_done;
    logic dup_read;
    logic sync_d;
    logic [31:0] rdata_d;
    logic [7:0] sel_off;

    assign mode = ctrl_one_q[adc_sync_pkg::MODE_LSB +: 2];
    assign fmt = ctrl_one_q[adc_sync_pkg::FMT_LSB +: 2];

    assign acq_on = ((mode == adc_sync_pkg::MODE_SINGLE_RUN)
        || (mode == adc_sync_pkg::MODE_CONTINUOUS))
        && (fmt != adc_sync_pkg::FMT_UNUSED);

    // one wait state: the access is taken on the edge before the one where pready is seen high
    assign take = psel & penable & ~pready_q;
    assign wr_take = take & pwrite;
    assign rd_take = take & ~pwrite;
    assign rd_one_hit = rd_take && (paddr == adc_sync_pkg::ADDR_RX_FIFO_ONE_DATA);
    assign rd_two_hit = rd_take && (paddr == adc_sync_pkg::ADDR_RX_FIFO_TWO_DATA);
    // selector window: wraps below the base, so low addresses never match
    assign sel_off = paddr - adc_sync_pkg::ADDR_IRQ_SEL_BASE;

    always_comb begin
        map_hit = 1'b1;
        rdata_d = 32'h0;
        case (paddr)
            adc_sync_pkg::ADDR_ACQ_CONTROL_ONE: rdata_d[3:0] = ctrl_one_q;
            adc_sync_pkg::ADDR_ACQ_CONTROL_THREE: rdata_d[1:0] = ctrl_three_q;
            adc_sync_pkg::ADDR_SYNC_STATUS: rdata_d[3:0] = st_q;
            adc_sync_pkg::ADDR_ACQ_ERROR_STATUS: rdata_d[adc_sync_pkg::SEQ_ERR_BIT] = seq_err_q;
            adc_sync_pkg::ADDR_RX_FIFO_ONE_DATA: begin
                rdata_d = rx_fifo_one_rdata;
                map_hit = ~pwrite;
            end
            adc_sync_pkg::ADDR_RX_FIFO_TWO_DATA: begin
                rdata_d = rx_fifo_two_rdata;
                map_hit = ~pwrite;
            end
            default: begin
                if (sel_off < 8'(4 * adc_sync_pkg::NUM_IRQ_LINES)
                    && sel_off[1:0] == 2'h0) begin
                    rdata_d[1:0] = irq_sel_q[sel_off[3:2]];
                end else begin
                    map_hit = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= take;
            pslverr_q <= take & ~map_hit;
            if (rd_take) begin
                prdata_q <= map_hit ? rdata_d : 32'h0;
            end
        end
    end

    // pops line up with the edge at which the read completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pop_one_q <= 1'b0;
            pop_two_q <= 1'b0;
        end else begin
            pop_one_q <= rd_one_hit;
            pop_two_q <= rd_two_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one_q <= adc_sync_pkg::RST_CONTROL_ONE;
            ctrl_three_q <= adc_sync_pkg::RST_CONTROL_THREE;
        end else if (wr_take) begin
            if (paddr == adc_sync_pkg::ADDR_ACQ_CONTROL_ONE) begin
                ctrl_one_q <= pwdata[3:0];
            end
            if (paddr == adc_sync_pkg::ADDR_ACQ_CONTROL_THREE) begin
                ctrl_three_q <= pwdata[1:0];
            end
        end
    end

    for (genvar i = 0; i < adc_sync_pkg::NUM_IRQ_LINES; i++) begin : g_line
        localparam logic [7:0] LINE_ADDR = adc_sync_pkg::ADDR_IRQ_SEL_BASE + 8'(4 * i);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                irq_sel_q[i] <= adc_sync_pkg::RST_IRQ_SEL;
            end else if (wr_take && paddr == LINE_ADDR) begin
                irq_sel_q[i] <= pwdata[1:0];
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                irq_n_q[i] <= 1'b1;
            end else begin
                case (irq_sel_q[i])
                    adc_sync_pkg::IRQ_SEL_POS: irq_n_q[i] <= ~sync_d;
                    adc_sync_pkg::IRQ_SEL_NEG: irq_n_q[i] <= sync_d;
                    default: irq_n_q[i] <= 1'b1;
                endcase
            end
        end
    end

    rx_event_select u_events (
        .fmt(fmt),
        .start_sel(ctrl_three_q[adc_sync_pkg::START_SEL_BIT]),
        .stop_sel(ctrl_three_q[adc_sync_pkg::STOP_SEL_BIT]),
        .one_full(one_full),
        .one_almost_full(one_almost_full),
        .one_empty(one_empty),
        .one_almost_empty(one_almost_empty),
        .two_full(two_full),
        .two_almost_full(two_almost_full),
        .two_empty(two_empty),
        .two_almost_empty(two_almost_empty),
        .start_evt(start_evt),
        .stop_evt(stop_evt)
    );

    // tracker is cleared whenever no synchronisation cycle is open
    rx_read_tracker u_reads (
        .pclk(pclk),
        .presetn(presetn),
        .fmt(fmt),
        .clear(st_q != adc_sync_pkg::S_WAIT),
        .rd_one(pop_one_q),
        .rd_two(pop_two_q),
        .done(reads_done),
        .dup(dup_read)
    );

    // sticky sequence error, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_err_q <= 1'b0;
        end else if (dup_read && st_q == adc_sync_pkg::S_WAIT) begin
            seq_err_q <= 1'b1;
        end else if (mode == adc_sync_pkg::MODE_CONFIG) begin
            seq_err_q <= 1'b0;
        end else if (wr_take && paddr == adc_sync_pkg::ADDR_ACQ_ERROR_STATUS
            && pwdata[adc_sync_pkg::SEQ_ERR_BIT]) begin
            seq_err_q <= 1'b0;
        end
    end

    always_comb begin
        st_d = st_q;
        case (st_q)
            adc_sync_pkg::S_IDLE: begin
                if (acq_on) st_d = adc_sync_pkg::S_HUNT;
            end
            adc_sync_pkg::S_HUNT: begin
                if (start_evt) st_d = adc_sync_pkg::S_WAIT;
            end
            adc_sync_pkg::S_WAIT: begin
                if (stop_evt || (dup_read && fmt == adc_sync_pkg::FMT_TWO_CHANNEL)) begin
                    st_d = adc_sync_pkg::S_HUNT;
                end else if (reads_done) begin
                    st_d = adc_sync_pkg::S_GAP;
                end
            end
            adc_sync_pkg::S_GAP: begin
                st_d = stop_evt ? adc_sync_pkg::S_HUNT : adc_sync_pkg::S_WAIT;
            end
            default: st_d = adc_sync_pkg::S_IDLE;
        endcase
        if (!acq_on) st_d = adc_sync_pkg::S_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= adc_sync_pkg::S_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_d = (st_d == adc_sync_pkg::S_WAIT);

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rx_fifo_one_pop = pop_one_q;
    assign rx_fifo_two_pop = pop_two_q;
    assign host_irq_n = irq_n_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_idle_off;
        !acq_on |=> st_q == adc_sync_pkg::S_IDLE;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("controller not idle when off");

    property p_hunt;
        st_q == adc_sync_pkg::S_IDLE && acq_on |=> st_q == adc_sync_pkg::S_HUNT;
    endproperty
    a_hunt: assert property (p_hunt) else $error("no hunt after mode set");

    property p_start;
        st_q == adc_sync_pkg::S_HUNT && acq_on && start_evt
            |=> st_q == adc_sync_pkg::S_WAIT
            && host_irq_n[0] == ($past(irq_sel_q[0]) != adc_sync_pkg::IRQ_SEL_POS);
    endproperty
    a_start: assert property (p_start) else $error("start event missed");

    property p_stop;
        st_q inside {adc_sync_pkg::S_WAIT, adc_sync_pkg::S_GAP} && acq_on && stop_evt
            |=> st_q == adc_sync_pkg::S_HUNT;
    endproperty
    a_stop: assert property (p_stop) else $error("stop event missed");

    property p_retrig;
        st_q == adc_sync_pkg::S_WAIT && acq_on && reads_done && !stop_evt && !dup_read
            |=> st_q == adc_sync_pkg::S_GAP ##1 st_q inside {adc_sync_pkg::S_WAIT, adc_sync_pkg::S_HUNT};
    endproperty
    a_retrig: assert property (p_retrig) else $error("sync not retriggered");

    property p_pos_line;
        irq_sel_q[2] == adc_sync_pkg::IRQ_SEL_POS && $stable(irq_sel_q[2])
            |-> host_irq_n[2] == (st_q != adc_sync_pkg::S_WAIT);
    endproperty
    a_pos_line: assert property (p_pos_line) else $error("positive sync not low");

    property p_neg_line;
        irq_sel_q[1] == adc_sync_pkg::IRQ_SEL_NEG && $stable(irq_sel_q[1])
            |-> host_irq_n[1] == (st_q == adc_sync_pkg::S_WAIT);
    endproperty
    a_neg_line: assert property (p_neg_line) else $error("negative sync not high");

    property p_pop_one;
        rd_one_hit |=> rx_fifo_one_pop && pready && !pslverr;
    endproperty
    a_pop_one: assert property (p_pop_one) else $error("fifo one read not popped");

    property p_seq_err;
        st_q == adc_sync_pkg::S_WAIT && dup_read |=> seq_err_q && st_q != adc_sync_pkg::S_WAIT;
    endproperty
    a_seq_err: assert property (p_seq_err) else $error("sequence error not flagged");

    property p_fmt_unused;
        fmt == adc_sync_pkg::FMT_UNUSED |=> st_q == adc_sync_pkg::S_IDLE && !sync_d;
    endproperty
    a_fmt_unused: assert property (p_fmt_unused) else $error("unused format not idle");

    c_two_ch: cover property (fmt == adc_sync_pkg::FMT_TWO_CHANNEL && st_q == adc_sync_pkg::S_GAP);
    c_err: cover property (seq_err_q && st_q == adc_sync_pkg::S_HUNT);
    c_retrig: cover property (st_q == adc_sync_pkg::S_GAP ##1 st_q == adc_sync_pkg::S_WAIT);
    c_neg_sync: cover property (irq_sel_q[1] == adc_sync_pkg::IRQ_SEL_NEG && host_irq_n[1]);
endmodule

/* File: rtl/adc_sync_pkg.sv */
// shared constants of the receive dma pacing controller
// assumes a 32-bit apb register port and one clock domain
package adc_sync_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_ACQ_CONTROL_ONE = 8'h00;
    localparam logic [7:0] ADDR_ACQ_CONTROL_THREE = 8'h04;
    localparam logic [7:0] ADDR_IRQ_SEL_BASE = 8'h08;
    localparam logic [7:0] ADDR_SYNC_STATUS = 8'h18;
    localparam logic [7:0] ADDR_ACQ_ERROR_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_RX_FIFO_ONE_DATA = 8'h20;
    localparam logic [7:0] ADDR_RX_FIFO_TWO_DATA = 8'h24;
    localparam int NUM_IRQ_LINES = 4;

    // acq_control_one fields
    localparam int MODE_LSB = 0;
    localparam int FMT_LSB = 2;
    // acq_control_three fields
    localparam int START_SEL_BIT = 0;
    localparam int STOP_SEL_BIT = 1;
    // acq_error_status field
    localparam int SEQ_ERR_BIT = 0;

    // acquisition mode codes
    localparam logic [1:0] MODE_CONFIG = 2'h0;
    localparam logic [1:0] MODE_SINGLE_RUN = 2'h1;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
    // channel format codes
    localparam logic [1:0] FMT_FIFO_ONE = 2'h0;
    localparam logic [1:0] FMT_FIFO_TWO = 2'h1;
    localparam logic [1:0] FMT_TWO_CHANNEL = 2'h2;
    localparam logic [1:0] FMT_UNUSED = 2'h3;
    // host irq line selector codes
    localparam logic [1:0] IRQ_SEL_OFF = 2'h0;
    localparam logic [1:0] IRQ_SEL_POS = 2'h1;
    localparam logic [1:0] IRQ_SEL_NEG = 2'h2;

    // reset values
    localparam logic [3:0] RST_CONTROL_ONE = 4'h0;
    localparam logic [1:0] RST_CONTROL_THREE = 2'h0;
    localparam logic [1:0] RST_IRQ_SEL = 2'h0;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_HUNT = 4'h2,
        S_WAIT = 4'h4,
        S_GAP = 4'h8
    } sync_state_t;

    // flags of fifo two are used only for the single-channel fifo two format
    function automatic logic uses_fifo_two(input logic [1:0] fmt);
        return fmt == FMT_FIFO_TWO;
    endfunction
endpackage

/* File: rtl/rx_event_select.sv */
// picks the start and stop events from the receive fifo flags
// assumes the flags are synchronous, active-high levels
`timescale 1ns/1ns
module rx_event_select (
    input wire logic [1:0] fmt,
    input wire logic start_sel,
    input wire logic stop_sel,
    input wire logic one_full,
    input wire logic one_almost_full,
    input wire logic one_empty,
    input wire logic one_almost_empty,
    input wire logic two_full,
    input wire logic two_almost_full,
    input wire logic two_empty,
    input wire logic two_almost_empty,
    output logic start_evt,
    output logic stop_evt
);
    logic full_pick;
    logic empty_pick;
    logic afull_pick;
    logic aempty_pick;

    always_comb begin
        full_pick = adc_sync_pkg::uses_fifo_two(fmt) ? two_full : one_full;
        afull_pick = adc_sync_pkg::uses_fifo_two(fmt) ? two_almost_full : one_almost_full;
        empty_pick = adc_sync_pkg::uses_fifo_two(fmt) ? two_empty : one_empty;
        aempty_pick = adc_sync_pkg::uses_fifo_two(fmt) ? two_almost_empty : one_almost_empty;
    end

    assign start_evt = start_sel ? afull_pick : full_pick;
    assign stop_evt = stop_sel ? aempty_pick : empty_pick;
endmodule

/* File: rtl/rx_read_tracker.sv */
// counts host data reads within one synchronisation cycle
// assumes read strobes are one-cycle pulses from the register port
`timescale 1ns/1ns
module rx_read_tracker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] fmt,
    input wire logic clear,
    input wire logic rd_one,
    input wire logic rd_two,
    output logic done,
    output logic dup
);
    logic got_one_q;
    logic got_two_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got_one_q <= 1'b0;
            got_two_q <= 1'b0;
        end else if (clear) begin
            got_one_q <= 1'b0;
            got_two_q <= 1'b0;
        end else begin
            got_one_q <= got_one_q | rd_one;
            got_two_q <= got_two_q | rd_two;
        end
    end

    always_comb begin
        case (fmt)
            adc_sync_pkg::FMT_FIFO_ONE: done = got_one_q;
            adc_sync_pkg::FMT_FIFO_TWO: done = got_two_q;
            adc_sync_pkg::FMT_TWO_CHANNEL: done = got_one_q & got_two_q;
            default: done = 1'b0;
        endcase
    end

    assign dup = (fmt == adc_sync_pkg::FMT_TWO_CHANNEL)
        & ((rd_one & got_one_q) | (rd_two & got_two_q));
endmodule

/* File: verif/rx_fifo_model.sv */
// behavioural receive fifo standing behind the controller's flag and data inputs
// assumes the bench loads a fill level and the controller pops on its own pulse
`timescale 1ns/1ns
module rx_fifo_model #(
    parameter logic [7:0] ID = 8'ha1,
    parameter int DEPTH = 8,
    parameter int AF_LEVEL = 6,
    parameter int AE_LEVEL = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [3:0] level,
    input wire logic pop,
    output logic full,
    output logic almost_full,
    output logic empty,
    output logic almost_empty,
    output logic [31:0] rdata
);
    logic [3:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
        end else if (load) begin
            cnt_q <= level;
        end else if (pop && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    assign full = cnt_q == 4'(DEPTH);
    assign almost_full = cnt_q >= 4'(AF_LEVEL);
    assign empty = cnt_q == 4'h0;
    assign almost_empty = cnt_q <= 4'(AE_LEVEL);
    // head word carries the id and fill level, so every read can be predicted
    assign rdata = {ID, 20'h0, cnt_q};
endmodule

/* File: verif/tb.sv */
// self-checking bench of the receive dma pacing controller
// assumes apb master here, two behavioural fifos, the bench reading as the host dma
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [1:0] fmt;
        logic ss;
        logic ts;
        logic [3:0] l1;
        logic [3:0] l2;
        logic [3:0] n;
    } row_t;
    row_t rows [7] = '{
        '{2'h0, 1'b0, 1'b0, 4'h7, 4'h8, 4'h0}, '{2'h0, 1'b0, 1'b0, 4'h8, 4'h0, 4'h8},
        '{2'h0, 1'b1, 1'b1, 4'h6, 4'h0, 4'h4}, '{2'h1, 1'b0, 1'b1, 4'h8, 4'h8, 4'h6},
        '{2'h1, 1'b1, 1'b0, 4'h0, 4'h6, 4'h6}, '{2'h2, 1'b0, 1'b1, 4'h8, 4'h8, 4'h6},
        '{2'h2, 1'b1, 1'b0, 4'h6, 4'h7, 4'h6}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ld, pop1, pop2, ev, hit, act;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv, d1, d2;
    logic f1, af1, e1, ae1, f2, af2, e2, ae2;
    logic [3:0] lv1, lv2, host_irq_n, exp_irq;
    int fail_count, checked, n, line;
    row_t r;

    adc_retrig_dma_sync dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .one_full(f1), .one_almost_full(af1), .one_empty(e1),
        .one_almost_empty(ae1), .two_full(f2), .two_almost_full(af2), .two_empty(e2),
        .two_almost_empty(ae2), .rx_fifo_one_rdata(d1), .rx_fifo_two_rdata(d2),
        .rx_fifo_one_pop(pop1), .rx_fifo_two_pop(pop2), .host_irq_n(host_irq_n));
    rx_fifo_model #(.ID(8'ha1)) fifo_one_u (.pclk(pclk), .presetn(presetn), .load(ld),
        .level(lv1), .pop(pop1), .full(f1), .almost_full(af1), .empty(e1),
        .almost_empty(ae1), .rdata(d1));
    rx_fifo_model #(.ID(8'ha2)) fifo_two_u (.pclk(pclk), .presetn(presetn), .load(ld),
        .level(lv2), .pop(pop2), .full(f2), .almost_full(af2), .empty(e2),
        .almost_empty(ae2), .rdata(d2));

    task automatic give_verdict;
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk("apb answer", 32'(k < 20), 32'h1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic load(input logic [3:0] a, input logic [3:0] b);
        @(posedge pclk);
        ld <= 1'b1;
        lv1 <= a;
        lv2 <= b;
        @(posedge pclk);
        ld <= 1'b0;
    endtask

    task automatic set_sel(input int l, input logic [1:0] code);
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, adc_sync_pkg::ADDR_IRQ_SEL_BASE + 8'(4 * j),
                32'((j == l) ? code : adc_sync_pkg::IRQ_SEL_OFF));
        end
    endtask

    task automatic wait_line(input int l, input logic lvl);
        hit = 1'b0;
        for (int i = 0; i < 12 && !hit; i++) begin
            @(posedge pclk);
            hit = host_irq_n[l] === lvl;
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        #2000000;
        fail_count++;
        give_verdict();
    end

    initial begin
        {presetn, psel, penable, pwrite, ld} = 5'h0;
        {paddr, pwdata, lv1, lv2} = 48'h0;
        repeat (6) @(posedge pclk);
        chk("reset lines", 32'(host_irq_n), 32'hf);
        presetn <= 1'b1;
        for (int j = 0; j < 8; j++) begin
            apb(1'b0, 8'(4 * j), 32'h0);
            chk("reset value", {rv[30:0], ev}, (j == 6) ? 32'h2 : 32'h0);
        end
        for (int i = 0; i < 7; i++) begin
            r = rows[i];
            line = i % 4;
            act = i[0];
            apb(1'b1, adc_sync_pkg::ADDR_ACQ_CONTROL_ONE, 32'h0);
            load(r.l1, r.l2);
            set_sel(line, act ? adc_sync_pkg::IRQ_SEL_NEG : adc_sync_pkg::IRQ_SEL_POS);
            apb(1'b1, adc_sync_pkg::ADDR_ACQ_CONTROL_THREE, {30'h0, r.ts, r.ss});
            exp_irq = 4'hf;
            exp_irq[line] = ~act;
            chk("parked line", 32'(host_irq_n), 32'(exp_irq));
            apb(1'b1, adc_sync_pkg::ADDR_ACQ_CONTROL_ONE, {28'h0, r.fmt,
                i[1] ? adc_sync_pkg::MODE_CONTINUOUS : adc_sync_pkg::MODE_SINGLE_RUN});
            n = 0;
            wait_line(line, act);
            if (hit) begin
                chk("active line", 32'(host_irq_n), 32'(exp_irq ^ (4'h1 << line)));
            end
            while (hit && n < 12) begin
                if (r.fmt != adc_sync_pkg::FMT_FIFO_TWO) begin
                    apb(1'b0, adc_sync_pkg::ADDR_RX_FIFO_ONE_DATA, 32'h0);
                    chk("fifo one data", rv, {8'ha1, 20'h0, r.l1 - 4'(n)});
                end
                if (r.fmt != adc_sync_pkg::FMT_FIFO_ONE) begin
                    apb(1'b0, adc_sync_pkg::ADDR_RX_FIFO_TWO_DATA, 32'h0);
                    chk("fifo two data", rv, {8'ha2, 20'h0, r.l2 - 4'(n)});
                end
                n++;
                wait_line(line, ~act);
                wait_line(line, act);
            end
            chk("sync cycles", 32'(n), 32'(r.n));
            apb(1'b0, adc_sync_pkg::ADDR_SYNC_STATUS, 32'h0);
            chk("hunting", rv, 32'h2);
        end
        apb(1'b0, 8'hfc, 32'h0);
        chk("unmapped error", {rv[30:0], ev}, 32'h1);
        apb(1'b1, adc_sync_pkg::ADDR_RX_FIFO_ONE_DATA, 32'h5);
        chk("data write error", 32'(ev), 32'h1);
        apb(1'b1, adc_sync_pkg::ADDR_ACQ_CONTROL_ONE, 32'h0);
        load(4'h8, 4'h8);
        set_sel(0, adc_sync_pkg::IRQ_SEL_POS);
        apb(1'b1, adc_sync_pkg::ADDR_ACQ_CONTROL_THREE, 32'h0);
        // unused format, then unused mode, with fifo one full
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, adc_sync_pkg::ADDR_ACQ_CONTROL_ONE, (j == 0) ? 32'hd : 32'h3);
            repeat (5) @(posedge pclk);
            chk("no sync", 32'(host_irq_n), 32'hf);
            apb(1'b0, adc_sync_pkg::ADDR_SYNC_STATUS, 32'h0);
            chk("idle", rv, 32'h1);
        end
        apb(1'b1, adc_sync_pkg::ADDR_ACQ_CONTROL_ONE, 32'h9);
        wait_line(0, 1'b0);
        chk("two channel start", 32'(hit), 32'h1);
        // a repeated read of fifo one breaks the pairing
        apb(1'b0, adc_sync_pkg::ADDR_RX_FIFO_ONE_DATA, 32'h0);
        apb(1'b0, adc_sync_pkg::ADDR_RX_FIFO_ONE_DATA, 32'h0);
        repeat (4) @(posedge pclk);
        apb(1'b0, adc_sync_pkg::ADDR_ACQ_ERROR_STATUS, 32'h0);
        chk("sequence error", rv, 32'h1);
        apb(1'b0, adc_sync_pkg::ADDR_SYNC_STATUS, 32'h0);
        chk("aborted", {rv[27:0], host_irq_n}, 32'h2f);
        apb(1'b1, adc_sync_pkg::ADDR_ACQ_ERROR_STATUS, 32'h1);
        apb(1'b0, adc_sync_pkg::ADDR_ACQ_ERROR_STATUS, 32'h0);
        chk("error cleared", rv, 32'h0);
        // reset in mid transfer parks the lines and the state
        load(4'h8, 4'h8);
        wait_line(0, 1'b0);
        apb(1'b0, adc_sync_pkg::ADDR_SYNC_STATUS, 32'h0);
        chk("open cycle", {rv[30:0], hit}, 32'h9);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("mid reset", {prdata[27:0], host_irq_n}, 32'hf);
        presetn <= 1'b1;
        apb(1'b0, adc_sync_pkg::ADDR_SYNC_STATUS, 32'h0);
        chk("after reset", {rv[27:0], host_irq_n}, 32'h1f);
        give_verdict();
    end
endmodule
